/* File: cssd_pkg.sv */
// Package for the clock source select and divider block.
// Holds register offsets, field positions, encodings and reset values.
// Assumes a plain word-addressed register port with byte addresses.
package cssd_pkg;

    // ****************************************
    // Geometry
    // ****************************************
    localparam int          NUM_CLK   = 4;
    localparam int          NUM_DIV   = 3;
    localparam int          SEL_W     = 4;
    localparam int          DIV_W     = 5;
    localparam int          ADDR_W    = 8;

    // ****************************************
    // Register byte offsets
    // ****************************************
    localparam logic [7:0]  OFF_SENSOR_SEL = 8'h00;
    localparam logic [7:0]  OFF_SENSOR_DIV = 8'h04;
    localparam logic [7:0]  OFF_NIC_SEL    = 8'h08;
    localparam logic [7:0]  OFF_NIC_DIV    = 8'h0C;
    localparam logic [7:0]  OFF_I2C_SEL    = 8'h10;
    localparam logic [7:0]  OFF_I2C_DIV    = 8'h14;
    localparam logic [7:0]  OFF_QSPI_SEL   = 8'h18;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int          SEL_LSB     = 0;
    localparam int          SEL_CUR_LSB = 8;
    localparam int          DIV_LSB     = 0;
    localparam int          DIV_CUR_LSB = 16;

    // ****************************************
    // Source encodings
    // ****************************************
    localparam logic [3:0]  SRC_REF = 4'h1;
    localparam logic [3:0]  SRC_PLL = 4'h2;

    // ****************************************
    // Reset values, channel 0 in the low slice
    // ****************************************
    localparam logic [NUM_CLK-1:0][SEL_W-1:0] SEL_RST = {SRC_REF, SRC_REF, SRC_PLL, SRC_PLL};
    localparam logic [DIV_W-1:0]               DIV_RST_SENSOR = 5'h17;
    localparam logic [DIV_W-1:0]               DIV_RST_NIC    = 5'h07;
    localparam logic [DIV_W-1:0]               DIV_RST_I2C    = 5'h00;
    localparam logic [NUM_CLK-1:0][DIV_W-1:0]  DIV_RST = {5'h00, DIV_RST_I2C, DIV_RST_NIC, DIV_RST_SENSOR};

endpackage : cssd_pkg

/* File: cssd_top.sv */
// Clock source select and divider for the sensor, interconnect, I2C and quad SPI clocks.
// Assumes clk is the system PLL clock; the reference clock arrives asynchronously.
// Each output clock is delivered as a one-cycle enable pulse per output period.
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/1ps

module cssd_top (
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       srst,
    // Reference clock pin
    input  wire logic                       reference_clock_input,
    // Register port
    input  wire logic [cssd_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]                reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic      [31:0]                reg_rdata,
    // Output clock enables
    output logic                            sensor_clock_en,
    output logic                            mgmt_interconnect_clock_en,
    output logic                            mgmt_i2c_clock_en,
    output logic                            mgmt_quad_spi_clock_en
);
    import cssd_pkg::*;

    // ****************************************
    // Reference clock sampling
    // ****************************************
    logic        ref_meta;
    logic        ref_sync;
    logic        ref_prev;
    logic        ref_rise;

    always_ff @(posedge clk) begin
        ref_meta <= reference_clock_input;
        ref_sync <= ref_meta;
        ref_prev <= ref_sync;
    end

    // Reference runs well below clk; one pulse per reference period
    assign ref_rise = ref_sync & ~ref_prev;

    // ****************************************
    // Register decode
    // ****************************************
    logic [ADDR_W-3:0]         word_idx;
    logic [NUM_CLK-1:0][3:0]   sel_req;
    logic [NUM_CLK-1:0][4:0]   div_req;
    logic [NUM_CLK-1:0][3:0]   sel_cur;
    logic [NUM_CLK-1:0][4:0]   div_cur;
    logic [NUM_CLK-1:0][4:0]   div_cnt;
    logic [NUM_CLK-1:0]        pll_wrap;
    logic [NUM_CLK-1:0]        clk_en;
    logic [31:0]               next_rdata;

    assign word_idx = reg_addr[ADDR_W-1:2];

    // ****************************************
    // Per-clock channels
    // ****************************************
    for (genvar c = 0; c < NUM_CLK; c++) begin : g_chan
        localparam logic [ADDR_W-3:0] SEL_IDX = (ADDR_W-2)'(2 * c);
        localparam logic [ADDR_W-3:0] DIV_IDX = (ADDR_W-2)'(2 * c + 1);

        // Source select field, reserved bits not stored
        always_ff @(posedge clk) begin
            if (srst) begin
                sel_req[c] <= SEL_RST[c];
            end else if (reg_wr && word_idx == SEL_IDX) begin
                sel_req[c] <= reg_wdata[SEL_LSB +: SEL_W];
            end
        end

        // Divider setting; quad SPI divider lives elsewhere and stays at 1
        if (c < NUM_DIV) begin : g_div
            always_ff @(posedge clk) begin
                if (srst) begin
                    div_req[c] <= DIV_RST[c];
                end else if (reg_wr && word_idx == DIV_IDX) begin
                    div_req[c] <= reg_wdata[DIV_LSB +: DIV_W];
                end
            end
        end else begin : g_nodiv
            assign div_req[c] = DIV_RST[c];
        end

        // PLL path counter; wraps after div_cur + 1 cycles
        assign pll_wrap[c] = (div_cnt[c] == div_cur[c]);

        always_ff @(posedge clk) begin
            if (srst) begin
                div_cnt[c] <= 5'h00;
            end else if (pll_wrap[c]) begin
                div_cnt[c] <= 5'h00;
            end else begin
                div_cnt[c] <= div_cnt[c] + 5'h01;
            end
        end

        // New ratio only at a period boundary, so no short pulse gap
        always_ff @(posedge clk) begin
            if (srst) begin
                div_cur[c] <= DIV_RST[c];
            end else if (pll_wrap[c]) begin
                div_cur[c] <= div_req[c];
            end
        end

        // Source change waits for a boundary of the source in use;
        // undefined select codes keep the present source
        always_ff @(posedge clk) begin
            if (srst) begin
                sel_cur[c] <= SEL_RST[c];
            end else if ((sel_req[c] == SRC_REF || sel_req[c] == SRC_PLL)
                         && ((sel_cur[c] == SRC_PLL) ? pll_wrap[c] : ref_rise)) begin
                sel_cur[c] <= sel_req[c];
            end
        end

        // Reference path bypasses the divider entirely
        always_ff @(posedge clk) begin
            if (srst) begin
                clk_en[c] <= 1'b0;
            end else begin
                clk_en[c] <= (sel_cur[c] == SRC_PLL) ? pll_wrap[c] : ref_rise;
            end
        end
    end

    assign sensor_clock_en            = clk_en[0];
    assign mgmt_interconnect_clock_en = clk_en[1];
    assign mgmt_i2c_clock_en          = clk_en[2];
    assign mgmt_quad_spi_clock_en     = clk_en[3];

    // ****************************************
    // Read path
    // ****************************************
    always_comb begin
        next_rdata = 32'h0000_0000;
        for (int i = 0; i < NUM_CLK; i++) begin
            if (word_idx == (ADDR_W-2)'(2 * i)) begin
                next_rdata[SEL_LSB +: SEL_W]     = sel_req[i];
                next_rdata[SEL_CUR_LSB +: SEL_W] = sel_cur[i];
            end
            if (i < NUM_DIV && word_idx == (ADDR_W-2)'(2 * i + 1)) begin
                next_rdata[DIV_LSB +: DIV_W]     = div_req[i];
                next_rdata[DIV_CUR_LSB +: DIV_W] = div_cur[i];
            end
        end
    end

    // Data stand only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (srst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // ****************************************
    // Elaboration checks
    // ****************************************
    if (ADDR_W < 5) begin : g_bad_addr
        $error("Address too narrow for the register map");
    end

    // ****************************************
    // Assertions
    // ****************************************
    sequence s_sel_write;
        reg_wr && word_idx == OFF_NIC_SEL[ADDR_W-1:2];
    endsequence

    sequence s_div_read;
        reg_rd && word_idx == OFF_SENSOR_DIV[ADDR_W-1:2];
    endsequence

    sequence s_div_write;
        reg_wr && word_idx == OFF_I2C_DIV[ADDR_W-1:2];
    endsequence

    sequence s_sel_read;
        reg_rd && word_idx == OFF_SENSOR_SEL[ADDR_W-1:2];
    endsequence

    sequence s_unmapped_read;
        reg_rd && word_idx >= (ADDR_W-2)'(2 * NUM_CLK - 1);
    endsequence

    // Divide by two: high, low, high
    sequence s_two_cycle_pulses;
        clk_en[1] ##1 !clk_en[1] ##1 clk_en[1];
    endsequence

    property p_sel_write;
        logic [3:0] v;
        @(posedge clk) disable iff (srst)
        (s_sel_write, v = reg_wdata[3:0]) |=> (sel_req[1] == v);
    endproperty
    a_sel_write: assert property (p_sel_write) else $error("Select write not stored");

    property p_cur_src_legal;
        @(posedge clk) disable iff (srst)
        (sel_cur[0] == SRC_REF || sel_cur[0] == SRC_PLL) && (sel_cur[1] == SRC_REF || sel_cur[1] == SRC_PLL)
        && (sel_cur[2] == SRC_REF || sel_cur[2] == SRC_PLL) && (sel_cur[3] == SRC_REF || sel_cur[3] == SRC_PLL);
    endproperty
    a_cur_src_legal: assert property (p_cur_src_legal) else $error("Current source holds an illegal code");

    property p_pll_ratio;
        @(posedge clk) disable iff (srst)
        (sel_cur[1] == SRC_PLL && pll_wrap[1] && div_cur[1] == 5'h01 && sel_req[1] == SRC_PLL
         && div_req[1] == 5'h01) |=> s_two_cycle_pulses;
    endproperty
    a_pll_ratio: assert property (p_pll_ratio) else $error("Divide by two pulse spacing wrong");

    property p_div_read;
        @(posedge clk) disable iff (srst)
        s_div_read |=> (reg_rdata[20:16] == $past(div_cur[0]) && reg_rdata[4:0] == $past(div_req[0])
                        && reg_rdata[31:21] == 11'h000 && reg_rdata[15:5] == 11'h000);
    endproperty
    a_div_read: assert property (p_div_read) else $error("Divider read data wrong");

    property p_ref_path;
        @(posedge clk) disable iff (srst)
        (sel_cur[2] == SRC_REF && ref_rise) |=> clk_en[2];
    endproperty
    a_ref_path: assert property (p_ref_path) else $error("Reference edge not passed through");

    property p_reset_values;
        @(posedge clk)
        $past(srst) |-> (sel_req[0] == SRC_PLL && sel_req[1] == SRC_PLL && sel_req[2] == SRC_REF
                         && sel_req[3] == SRC_REF && div_req[0] == 5'h17 && div_req[1] == 5'h07
                         && div_req[2] == 5'h00);
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("Reset values wrong");

    property p_div_change_at_wrap;
        @(posedge clk) disable iff (srst)
        $changed(div_cur[0]) |-> $past(pll_wrap[0]);
    endproperty
    a_div_change_at_wrap: assert property (p_div_change_at_wrap) else $error("Divider changed mid period");

    property p_src_change_at_edge;
        @(posedge clk) disable iff (srst)
        $changed(sel_cur[0]) |-> ($past(sel_cur[0]) == SRC_PLL ? $past(pll_wrap[0]) : $past(ref_rise));
    endproperty
    a_src_change_at_edge: assert property (p_src_change_at_edge) else $error("Source switched mid period");

    property p_rdata_one_cycle;
        @(posedge clk) disable iff (srst)
        !reg_rd |=> reg_rdata == 32'h0000_0000;
    endproperty
    a_rdata_one_cycle: assert property (p_rdata_one_cycle) else $error("Read data outside its cycle");

    // ****************************************
    // Register port checks
    // ****************************************
    property p_div_write;
        logic [4:0] v;
        @(posedge clk) disable iff (srst)
        (s_div_write, v = reg_wdata[4:0]) |=> (div_req[2] == v);
    endproperty
    a_div_write: assert property (p_div_write) else $error("Divider write not stored");

    property p_sel_read;
        @(posedge clk) disable iff (srst)
        s_sel_read |=> (reg_rdata[31:12] == 20'h0_0000 && reg_rdata[7:4] == 4'h0
                        && reg_rdata[3:0] == $past(sel_req[0]) && reg_rdata[11:8] == $past(sel_cur[0]));
    endproperty
    a_sel_read: assert property (p_sel_read) else $error("Select read data wrong");

    property p_unmapped_read;
        @(posedge clk) disable iff (srst)
        s_unmapped_read |=> (reg_rdata == 32'h0000_0000);
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) else $error("Unmapped read not zero");

    // Nothing leaks out while reset is held
    property p_en_reset;
        @(posedge clk)
        srst |=> (clk_en == '0 && reg_rdata == 32'h0000_0000);
    endproperty
    a_en_reset: assert property (p_en_reset) else $error("Output active during reset");

    // ****************************************
    // Clock path checks
    // ****************************************
    property p_sel_hold_illegal;
        @(posedge clk) disable iff (srst)
        (sel_req[1] != SRC_REF && sel_req[1] != SRC_PLL) |=> $stable(sel_cur[1]);
    endproperty
    a_sel_hold_illegal: assert property (p_sel_hold_illegal) else $error("Illegal code moved the source");

    property p_pll_path;
        @(posedge clk) disable iff (srst)
        (sel_cur[0] == SRC_PLL) |=> (clk_en[0] == $past(pll_wrap[0]));
    endproperty
    a_pll_path: assert property (p_pll_path) else $error("PLL path pulse wrong");

    property p_ref_no_div;
        @(posedge clk) disable iff (srst)
        (sel_cur[0] == SRC_REF) |=> (clk_en[0] == $past(ref_rise));
    endproperty
    a_ref_no_div: assert property (p_ref_no_div) else $error("Reference path divided");

    // Reference pulses are one cycle, so none back to back
    property p_ref_single;
        @(posedge clk) disable iff (srst)
        ($past(sel_cur[2]) == SRC_REF && sel_cur[2] == SRC_REF && clk_en[2]) |=> !clk_en[2];
    endproperty
    a_ref_single: assert property (p_ref_single) else $error("Reference pulse too long");

    property p_div_cur_follows;
        @(posedge clk) disable iff (srst)
        pll_wrap[1] |=> (div_cur[1] == $past(div_req[1]));
    endproperty
    a_div_cur_follows: assert property (p_div_cur_follows) else $error("Current divider not taken");

    // Counter never overshoots, else a period would stretch to 32
    property p_cnt_bound;
        @(posedge clk) disable iff (srst)
        div_cnt[2] <= div_cur[2];
    endproperty
    a_cnt_bound: assert property (p_cnt_bound) else $error("Divider counter overshoot");

endmodule : cssd_top

/* File: cssd_top_bench.sv */
// Self-checking bench for the clock source select and divider block.
// Assumes cssd_pkg and cssd_top are compiled first; the bench makes the reference clock.
`timescale 1ns/1ps

module cssd_top_bench;
    import cssd_pkg::*;

    `define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin err_count++; \
        $display("mismatch t=%0t got=%h exp=%h", $time, (got), (exp)); end end

    // ****************************************
    // Signals
    // ****************************************
    logic              clk;
    logic              srst;
    logic              reference_clock_input;
    logic              reg_wr;
    logic              reg_rd;
    logic [ADDR_W-1:0] reg_addr;
    logic [31:0]       reg_wdata;
    logic [31:0]       reg_rdata;
    logic [31:0]       rd_val;
    logic [31:0]       d;
    logic [3:0]        en_vec;
    logic [3:0]        ref_cnt;
    int                err_count;
    int                compares;
    int                seed;

    // Reference clock runs at clk/16, well under the clk/2 limit
    localparam int     REF_PER = 16;

    cssd_top cssd_top_inst (
        .clk                        (clk),
        .srst                       (srst),
        .reference_clock_input      (reference_clock_input),
        .reg_addr                   (reg_addr),
        .reg_wdata                  (reg_wdata),
        .reg_wr                     (reg_wr),
        .reg_rd                     (reg_rd),
        .reg_rdata                  (reg_rdata),
        .sensor_clock_en            (en_vec[0]),
        .mgmt_interconnect_clock_en (en_vec[1]),
        .mgmt_i2c_clock_en          (en_vec[2]),
        .mgmt_quad_spi_clock_en     (en_vec[3])
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        ref_cnt               <= ref_cnt + 4'h1;
        reference_clock_input <= ref_cnt[3];
    end

    // ****************************************
    // Expectations and bus tasks
    // ****************************************
    function automatic logic [31:0] sel_word(input logic [3:0] s, input logic [3:0] c);
        return {20'h0_0000, c, 4'h0, s};
    endfunction : sel_word

    function automatic logic [31:0] div_word(input logic [4:0] s, input logic [4:0] c);
        return {11'h000, c, 11'h000, s};
    endfunction : div_word

    task automatic end_sim();
        if (err_count == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim

    task automatic wr(input int a, input logic [31:0] v);
        @(posedge clk);
        reg_addr  <= ADDR_W'(a);
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input int a);
        @(posedge clk);
        reg_addr <= ADDR_W'(a);
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask : rd

    task automatic chk_rst();
        for (int i = 0; i < 4; i++) begin
            rd(8 * i);
            `CHK(rd_val, sel_word(SEL_RST[i], SEL_RST[i]))
            if (i < 3) begin
                rd(8 * i + 4);
                `CHK(rd_val, div_word(DIV_RST[i], DIV_RST[i]))
            end
        end
    endtask : chk_rst

    // Edges from one enable pulse to the next; bounded so a dead output ends the run
    task automatic period(input int ch, input int exp);
        int n;
        n = 0;
        while (en_vec[ch] !== 1'b1 && n < 300) begin
            @(posedge clk);
            #1 n++;
        end
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while (en_vec[ch] !== 1'b1 && n < 300);
        `CHK(n, exp)
        if (n >= 300) end_sim();
    endtask : period

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        srst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        ref_cnt = 4'h0;
        reference_clock_input = 1'b0;
        err_count = 0;
        compares = 0;
        seed = 32'hde44;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        chk_rst();
        period(0, 24);
        period(1, 8);
        period(2, REF_PER);
        period(3, REF_PER);
        // Move I2C and quad SPI onto the PLL path, reserved bits set in the I2C write
        wr(8'h10, 32'hffff_fff2);
        wr(8'h18, 32'h0000_0002);
        repeat (80) @(posedge clk);
        rd(8'h10);
        `CHK(rd_val, sel_word(4'h2, 4'h2))
        period(3, 1);
        for (int k = 0; k < 3; k++) begin
            for (int i = 0; i < 3; i++) begin
                d = (k == 0) ? 32'hffff_ffff : (k == 1) ? 32'hffff_ffe0 : $random(seed);
                wr(8 * i + 4, d);
                rd(8 * i + 4);
                `CHK(rd_val[15:0], {11'h000, d[4:0]})
                `CHK(rd_val[31:21], 11'h000)
                repeat (80) @(posedge clk);
                rd(8 * i + 4);
                `CHK(rd_val, div_word(d[4:0], d[4:0]))
                period(i, int'(d[4:0]) + 1);
            end
        end
        // Sensor onto the reference clock; its divider must not matter there
        wr(8'h00, 32'h0000_0001);
        repeat (80) @(posedge clk);
        rd(8'h00);
        `CHK(rd_val, sel_word(4'h1, 4'h1))
        period(0, REF_PER);
        wr(8'h04, 32'h0000_0005);
        period(0, REF_PER);
        // Unknown select code is kept but the source stays on the PLL
        wr(8'h0c, 32'h0000_0003);
        wr(8'h08, 32'h0000_0003);
        repeat (80) @(posedge clk);
        rd(8'h08);
        `CHK(rd_val, sel_word(4'h3, 4'h2))
        period(1, 4);
        wr(8'h08, 32'h0000_0002);
        wr(8'h0c, 32'h0000_0001);
        repeat (20) @(posedge clk);
        period(1, 2);
        rd(8'h1c);
        `CHK(rd_val, 32'h0000_0000)
        rd(8'h04);
        @(posedge clk);
        #1 `CHK(reg_rdata, 32'h0000_0000)
        // Mid-run reset must bring every field back
        @(posedge clk);
        srst <= 1'b1;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        chk_rst();
        period(0, 24);
        end_sim();
    end

endmodule : cssd_top_bench
